// ==== bench/cfg_loader_checker.sv ====
/* Assertions on the loader pins.
   Assumes binding into spi_flash_config_loader. */
`timescale 1ns/1ps
module cfg_loader_checker (
	input wire logic i_core_clk,
	input wire logic i_resetn,
	input wire logic i_init_status,
	input wire logic i_done_status,
	input wire cfg_loader_pkg::spi_pins_t o_spi,
	input wire logic o_clear_n,
	input wire logic o_busy,
	input wire logic o_success,
	input wire logic o_used_golden,
	input wire logic o_failed
);
	import cfg_loader_pkg::*;
	// ****************************************
	// Pin checks
	// ****************************************
	logic [7:0] low_q, low_d;
	// Clear low time; saturates so a stuck pin cannot wrap
	always_comb low_d = o_clear_n ? 8'h00 : low_q + {7'h00, ~&low_q};
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) low_q <= 8'h00;
		else low_q <= low_d;
	end
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_resetn);
	property p_clear; $rose(o_clear_n) |-> low_q >= CLEAR_PULSE_CYCLES; endproperty
	a_clear: assert property (p_clear) else $error("clear short");
	property p_gate; $fell(o_spi.cs_n) |-> i_init_status && o_clear_n; endproperty
	a_gate: assert property (p_gate) else $error("read early");
	property p_idle; o_spi.cs_n |-> !o_spi.sclk; endproperty
	a_idle: assert property (p_idle) else $error("clock idle high");
	property p_hold; o_spi.sclk && $past(o_spi.sclk) |-> $stable(o_spi.mosi);
	endproperty
	a_hold: assert property (p_hold) else $error("data moved high");
	property p_start; $rose(o_busy) |=> $fell(o_clear_n); endproperty
	a_start: assert property (p_start) else $error("no clear");
	property p_ok; $rose(o_success) |-> i_init_status && i_done_status; endproperty
	a_ok: assert property (p_ok) else $error("bad success");
	property p_fall; $rose(o_used_golden) |-> ##[0:4] !o_clear_n; endproperty
	a_fall: assert property (p_fall) else $error("no reclear");
	property p_fail; $rose(o_failed) |-> o_used_golden && !o_success; endproperty
	a_fail: assert property (p_fail) else $error("early fail");
	property p_frame; !o_busy |-> o_spi.cs_n; endproperty
	a_frame: assert property (p_frame) else $error("stray select");
	c_ok: cover property ($rose(o_success));
	c_gold: cover property ($rose(o_used_golden));
	c_fail: cover property ($rose(o_failed));
endmodule
bind spi_flash_config_loader cfg_loader_checker chk (.i_core_clk, .i_resetn,
	.i_init_status, .i_done_status, .o_spi, .o_clear_n, .o_busy, .o_success,
	.o_used_golden, .o_failed);

// ==== bench/flash_target_model.sv ====
/* Flash and target stand-in on the shared serial bus.
   Assumes mode 0 frames from the controller on i_spi. */
`timescale 1ns/1ps
module flash_target_model (
	input wire cfg_loader_pkg::spi_pins_t i_spi,
	input wire logic i_clear_n,
	input wire logic [23:0] i_good_addr,
	output logic o_init,
	output logic o_done,
	output logic [31:0] o_hdr,
	output int o_bits,
	output int o_frames
);
	import cfg_loader_pkg::*;
	// ****************************************
	// Behaviour
	// ****************************************
	logic [31:0] sr;
	logic [7:0] cur;
	logic drv, synced;
	int tail;
	// Released line shows the inverse, never a stale bit
	wire miso = i_spi.cs_n ? ~drv : drv;
	// Only the image at the good address carries the sync word
	function automatic logic [7:0] img(input int k);
		logic [31:0] s;
		s = 32'hAA995566 >> (8 * (3 - k));
		if (o_hdr[23:0] !== i_good_addr) return 8'hFF;
		return k > 3 ? 8'h5A : s[7:0];
	endfunction
	initial {o_init, o_done, o_hdr, o_bits, o_frames, drv, sr, synced, tail} = '0;
	always @(negedge i_spi.cs_n) begin
		o_bits = 0;
		o_frames++;
	end
	// Header bits taken on rising edges; target snoops the same edge
	always @(posedge i_spi.sclk) begin
		if (!i_spi.cs_n && o_bits < 32) o_hdr = {o_hdr[30:0], i_spi.mosi};
		if (!i_spi.cs_n) o_bits++;
		if (o_init && !o_done) begin
			sr = {sr[30:0], miso};
			if (synced) tail++;
			synced |= sr === 32'hAA995566;
			o_done = tail >= 64;
		end
	end
	always @(negedge i_spi.sclk) begin
		if (!i_spi.cs_n && o_bits >= 32) begin
			cur = img((o_bits - 32) / 8);
			drv = cur[7 - (o_bits - 32) % 8];
		end
	end
	// Clear wipes the target; init returns a while after release
	always @(i_clear_n) begin
		if (!i_clear_n) {o_init, o_done, synced, tail, sr} = '0;
		else #300 o_init = 1'b1;
	end
endmodule

// ==== bench/tb.sv ====
/* Self-checking bench for the configuration loader.
   Assumes the model and checker are compiled first. */
`timescale 1ns/1ps
module tb;
	import cfg_loader_pkg::*;
	// ****************************************
	// Bench
	// ****************************************
	logic clk = 1'b0, rst_n = 1'b0, start = 1'b0;
	logic [7:0] div = 8'h00;
	logic [23:0] good = 24'h000000;
	image_desc_t img = '0;
	spi_pins_t spi;
	logic clr_n, busy, ok, gold, fail, init, done;
	logic [31:0] hdr, seed = 32'd43511;
	int bits, frames, bad_count = 0, cmp_count = 0;
	always #2.5 clk = ~clk;
	spi_flash_config_loader dut (.i_core_clk(clk), .i_resetn(rst_n),
		.i_start(start), .i_image(img), .i_sclk_half_div(div),
		.i_init_status(init), .i_done_status(done), .o_spi(spi),
		.o_clear_n(clr_n), .o_busy(busy), .o_success(ok),
		.o_used_golden(gold), .o_failed(fail));
	flash_target_model fm (.i_spi(spi), .i_clear_n(clr_n), .i_good_addr(good),
		.o_init(init), .o_done(done), .o_hdr(hdr), .o_bits(bits),
		.o_frames(frames));
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Address the final frame must carry
	function automatic logic [23:0] exp_addr(input int sel);
		return sel == 0 ? img.latest_addr : img.golden_addr;
	endfunction
	task automatic chk(input string what, input logic [31:0] exp, got);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic final_report();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Inputs move 1 ns after the edge so sampling never races
	task automatic tick();
		@(posedge clk);
		#1;
	endtask
	// One load: sel 0 latest good, 1 only golden good, 2 neither
	task automatic run(input int sel, input logic [31:0] n, input logic [7:0] d);
		logic [31:0] r;
		int f0, w;
		r = xs();
		img = '{r[23:0], r[23:0] ^ 24'h800000, n};
		div = d;
		good = sel == 0 ? r[23:0] : sel == 1 ? img.golden_addr : ~r[23:0];
		f0 = frames;
		start = 1'b1;
		for (w = 0; w < 20 && busy !== 1'b1; w++) tick();
		start = 1'b0;
		for (w = 0; w < 30000 && busy !== 1'b0; w++) tick();
		tick();
		chk("busy", 0, busy);
		chk("success", sel != 2, ok);
		chk("golden", sel != 0, gold);
		chk("failed", sel == 2, fail);
		chk("frames", sel == 0 ? 1 : 2, frames - f0);
		chk("header", {FLASH_READ_CMD, exp_addr(sel)}, hdr);
		chk("bits", n * 8, bits);
		start = 1'b1;
		tick();
		start = 1'b0;
		repeat (2) tick();
	endtask
	initial begin
		repeat (10) @(posedge clk);
		#1 rst_n = 1'b1;
		repeat (3) tick();
		run(0, 16, 8'h00);
		run(1, 16, 8'h01);
		run(2, 20, 8'h02);
		for (int i = 0; i < 6; i++) run(i % 3, 16 + xs() % 16, 8'(xs() % 4));
		final_report();
	end
	initial begin
		#450000;
		bad_count++;
		final_report();
	end
endmodule

// ==== rtl/cfg_loader_pkg.sv ====
/*
 * Shared constants and types for the serial flash configuration loader.
 * Assumes a 200 MHz core clock; no other package is needed.
 */
package cfg_loader_pkg;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CORE_CLK_MHZ = 200;
	// Least clear pulse time in ns; the pulse is held for at least this
	localparam int CLEAR_PULSE_MIN_TIME_NS = 500;
	localparam int CLEAR_PULSE_CYCLES =
		(CLEAR_PULSE_MIN_TIME_NS * CORE_CLK_MHZ + 999) / 1000 + 1;
	// Serial clock divider; each half period lasts this value plus one core cycles
	localparam logic [7:0] SCLK_HALF_DIV_RST = 8'h04;
	// Settle time after transfer before status is judged, in cycles
	localparam int STATUS_SETTLE_CYCLES = 64;

	// ****************************************************************
	// Flash command and header
	// ****************************************************************
	localparam logic [7:0] FLASH_READ_CMD = 8'h03;
	localparam int HEADER_BYTES = 4;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [3:0] {
		ST_IDLE    = 4'b0000,
		ST_SETUP   = 4'b0001,
		ST_CLEAR   = 4'b0010,
		ST_WAIT_IN = 4'b0011,
		ST_XFER    = 4'b0100,
		ST_SETTLE  = 4'b0101,
		ST_CHECK   = 4'b0110,
		ST_DONE    = 4'b0111,
		ST_FAIL    = 4'b1000
	} load_state_t;

	// Image selection handed to the loader
	typedef struct packed {
		logic [23:0] latest_addr;
		logic [23:0] golden_addr;
		logic [31:0] byte_count;
	} image_desc_t;

	// Serial bus pins driven by the controller
	typedef struct packed {
		logic sclk;
		logic cs_n;
		logic mosi;
	} spi_pins_t;

endpackage

// ==== rtl/spi_byte_shifter.sv ====
/*
 * Single-bit SPI mode 0 byte shifter with a programmable clock divider.
 * Assumes the caller holds chip select and feeds a new byte on o_ready.
 */
`timescale 1ns/1ps
module spi_byte_shifter (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic [7:0] i_half_div,
	input wire logic i_valid,
	input wire logic [7:0] i_byte,
	output logic o_ready,
	output logic o_sclk,
	output logic o_mosi
);
	import cfg_loader_pkg::*;

	logic [7:0] div_q, div_d;
	logic [2:0] bit_q, bit_d;
	logic [7:0] sh_q, sh_d;
	logic busy_q, busy_d;
	logic sclk_q, sclk_d;

	// Ready whenever no byte is in flight; chained bytes stretch the low phase by one core cycle
	assign o_ready = !busy_q;
	assign o_sclk = sclk_q;
	assign o_mosi = sh_q[7];

	// ****************************************************************
	// Shift engine
	// ****************************************************************
	// Clock idles low; data changes on the falling edge
	always_comb begin
		div_d = div_q;
		bit_d = bit_q;
		sh_d = sh_q;
		busy_d = busy_q;
		sclk_d = sclk_q;
		if (!busy_q) begin
			if (i_valid) begin
				sh_d = i_byte; // MSB first
				busy_d = 1'b1;
				bit_d = 3'h0;
				div_d = i_half_div;
			end
		end else if (div_q != 8'h00) begin
			div_d = div_q - 8'h01;
		end else begin
			div_d = i_half_div;
			sclk_d = !sclk_q;
			if (sclk_q) begin
				// Falling edge launches next bit
				sh_d = {sh_q[6:0], 1'b0};
				bit_d = bit_q + 3'h1;
				if (bit_q == 3'h7) begin
					busy_d = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			div_q <= 8'h00;
			bit_q <= 3'h0;
			sh_q <= 8'h00;
			busy_q <= 1'b0;
			sclk_q <= 1'b0;
		end else begin
			div_q <= div_d;
			bit_q <= bit_d;
			sh_q <= sh_d;
			busy_q <= busy_d;
			sclk_q <= sclk_d;
		end
	end
endmodule

// ==== rtl/spi_flash_config_loader.sv ====
/*
 * Controller that loads a target logic device from a serial flash over a
 * shared SPI bus, trying the latest image first and the golden one after.
 * Assumes the target snoops the flash data line and serial clock, and that
 * its init and done status pins arrive asynchronously.
 */
`timescale 1ns/1ps
module spi_flash_config_loader (
	input wire logic i_core_clk,
	input wire logic i_resetn,
	input wire logic i_start,
	input wire cfg_loader_pkg::image_desc_t i_image,
	input wire logic [7:0] i_sclk_half_div,
	input wire logic i_init_status,
	input wire logic i_done_status,
	output cfg_loader_pkg::spi_pins_t o_spi,
	output logic o_clear_n,
	output logic o_busy,
	output logic o_success,
	output logic o_used_golden,
	output logic o_failed
);
	import cfg_loader_pkg::*;

	// ****************************************************************
	// Reset release and pin synchronisers
	// ****************************************************************
	logic rst_meta_q, rst_n_q;
	logic [1:0] init_sync_q, done_sync_q;
	logic init_s, done_s;

	// Reset asserts at once but releases through two flops
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end

	// Status pins are asynchronous; only the second flop is read
	always_ff @(posedge i_core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			init_sync_q <= 2'b00;
			done_sync_q <= 2'b00;
		end else begin
			init_sync_q <= {init_sync_q[0], i_init_status};
			done_sync_q <= {done_sync_q[0], i_done_status};
		end
	end
	assign init_s = init_sync_q[1];
	assign done_s = done_sync_q[1];

	// ****************************************************************
	// Sequencer state
	// ****************************************************************
	load_state_t st_q, st_d;
	logic [31:0] cnt_q, cnt_d;
	logic [31:0] sent_q, sent_d;
	logic golden_q, golden_d;
	logic [7:0] div_q, div_d;
	logic cs_n_q, cs_n_d;
	logic clear_n_q, clear_n_d;
	logic success_q, success_d;
	logic failed_q, failed_d;
	image_desc_t img_q, img_d;
	logic tx_valid, tx_ready, tx_sclk, tx_mosi;
	logic [7:0] tx_byte;
	logic [23:0] cur_addr;

	// Header byte for a given position, filler of zeros afterwards
	function automatic logic [7:0] header_byte(input logic [31:0] idx,
		input logic [23:0] addr);
		logic [7:0] b;
		b = 8'h00; // Filler is ignored by the flash
		unique case (idx)
			32'h0: b = FLASH_READ_CMD;
			32'h1: b = addr[23:16];
			32'h2: b = addr[15:8];
			32'h3: b = addr[7:0];
			default: b = 8'h00;
		endcase
		return b;
	endfunction

	assign cur_addr = golden_q ? img_q.golden_addr : img_q.latest_addr;
	assign tx_byte = header_byte(sent_q, cur_addr);
	assign tx_valid = (st_q == ST_XFER) && (sent_q < img_q.byte_count);

	// Next-state logic for the load sequence
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		sent_d = sent_q;
		golden_d = golden_q;
		div_d = div_q;
		cs_n_d = cs_n_q;
		clear_n_d = clear_n_q;
		success_d = success_q;
		failed_d = failed_q;
		img_d = img_q;
		unique case (st_q)
			ST_IDLE: begin
				if (i_start) begin
					img_d = i_image;
					golden_d = 1'b0; // Latest image first
					success_d = 1'b0;
					failed_d = 1'b0;
					st_d = ST_SETUP;
				end
			end
			ST_SETUP: begin
				// Divider latched and clear pulse started up front
				div_d = (i_sclk_half_div == 8'h00) ? 8'h01 : i_sclk_half_div;
				clear_n_d = 1'b0;
				cnt_d = 32'h0;
				st_d = ST_CLEAR;
			end
			ST_CLEAR: begin
				cnt_d = cnt_q + 32'h1;
				if (cnt_q >= 32'(CLEAR_PULSE_CYCLES)) begin
					clear_n_d = 1'b1;
					st_d = ST_WAIT_IN;
				end
			end
			ST_WAIT_IN: begin
				// Wait for memory clearing to finish
				if (init_s) begin
					sent_d = 32'h0;
					cs_n_d = 1'b0;
					st_d = ST_XFER;
				end
			end
			ST_XFER: begin
				// One continuous read, select held low and
				if (tx_valid && tx_ready) begin
					sent_d = sent_q + 32'h1;
				end
				// Stop only after full byte count
				if (!tx_valid && tx_ready) begin
					cs_n_d = 1'b1;
					cnt_d = 32'h0;
					st_d = ST_SETTLE;
				end
			end
			ST_SETTLE: begin
				cnt_d = cnt_q + 32'h1;
				if (cnt_q >= 32'(STATUS_SETTLE_CYCLES)) begin
					st_d = ST_CHECK;
				end
			end
			ST_CHECK: begin
				if (init_s && done_s) begin
					success_d = 1'b1;
					st_d = ST_DONE;
				end else if (!golden_q) begin
					golden_d = 1'b1; // Fall back to golden
					st_d = ST_SETUP;
				end else begin
					failed_d = 1'b1;
					st_d = ST_FAIL;
				end
			end
			ST_DONE, ST_FAIL: begin
				if (i_start) begin
					st_d = ST_IDLE;
				end
			end
			default: st_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge i_core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			st_q <= ST_IDLE;
			cnt_q <= 32'h0;
			sent_q <= 32'h0;
			golden_q <= 1'b0;
			div_q <= SCLK_HALF_DIV_RST;
			cs_n_q <= 1'b1;
			clear_n_q <= 1'b1;
			success_q <= 1'b0;
			failed_q <= 1'b0;
			img_q <= '0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			sent_q <= sent_d;
			golden_q <= golden_d;
			div_q <= div_d;
			cs_n_q <= cs_n_d;
			clear_n_q <= clear_n_d;
			success_q <= success_d;
			failed_q <= failed_d;
			img_q <= img_d;
		end
	end

	// ****************************************************************
	// Single-bit shifter
	// ****************************************************************
	// Only one data line is used; the target watches that line and the serial clock
	spi_byte_shifter u_shift (
		.i_core_clk(i_core_clk),
		.i_rst_n(rst_n_q),
		.i_half_div(div_q),
		.i_valid(tx_valid),
		.i_byte(tx_byte),
		.o_ready(tx_ready),
		.o_sclk(tx_sclk),
		.o_mosi(tx_mosi)
	);

	assign o_spi.sclk = tx_sclk;
	assign o_spi.cs_n = cs_n_q;
	assign o_spi.mosi = tx_mosi;
	assign o_clear_n = clear_n_q;
	assign o_busy = (st_q != ST_IDLE) && (st_q != ST_DONE) &&
		(st_q != ST_FAIL);
	assign o_success = success_q;
	assign o_used_golden = golden_q;
	assign o_failed = failed_q;
endmodule
